/* rtl/psd_if.sv */
`default_nettype none
interface psd_if;
  logic fibre;
  logic autoneg;
  logic speed;
  logic duplex;
  logic [8:0] value;
  modport map (input fibre, input autoneg, input speed, input duplex, output value);
  modport user (output fibre, output autoneg, output speed, output duplex, input value);
endinterface
`default_nettype wire

/* rtl/psd_phyb_map.sv */
`default_nettype none
module psd_phyb_map
  import psd_pkg::*;
(
  psd_if.map m
);
  logic an;
  logic sp;
  logic dp;
  logic [2:0] mode;
  always_comb
  begin
    // Fibre pins autoneg off and speed at 100; duplex has no fibre exemption so it still follows its strap
    an = m.fibre ? 1'b0 : m.autoneg;
    sp = m.fibre ? 1'b1 : m.speed;
    dp = m.duplex;
    if (an)
      mode = PSD_MODE_AN;
    else
      mode = {1'b0, sp, dp};
    m.value = '0;
    m.value[PSD_B_AN_EN] = an;
    m.value[PSD_B_SPEED_LSB] = an ? 1'b1 : sp;
    m.value[PSD_B_DUPLEX] = an ? 1'b1 : dp;
    m.value[PSD_B_ADV_10FD] = (an | ~sp) & dp;
    m.value[PSD_B_ADV_10HD] = an | ~sp;
    m.value[PSD_B_MODE_LO +: 3] = mode;
  end
endmodule
`default_nettype wire

/* rtl/psd_pkg.sv */
`default_nettype none
package psd_pkg;
  localparam logic [3:0] PSD_ADDR_PHYA = 4'h0;
  localparam logic [3:0] PSD_ADDR_PHYB = 4'h1;
  localparam logic [3:0] PSD_ADDR_HWCFG = 4'h2;
  localparam logic [3:0] PSD_ADDR_XOVER = 4'h3;
  localparam logic [3:0] PSD_ADDR_STRAPS = 4'h4;
  // PHY A register bits
  localparam int PSD_A_EEE_EN = 0;
  localparam int PSD_A_EEE_CAP = 1;
  localparam int PSD_A_EEE_ADV = 2;
  // PHY B register bits
  localparam int PSD_B_AN_EN = 0;
  localparam int PSD_B_SPEED_LSB = 1;
  localparam int PSD_B_DUPLEX = 2;
  localparam int PSD_B_ADV_10FD = 3;
  localparam int PSD_B_ADV_10HD = 4;
  localparam int PSD_B_MODE_LO = 5;
  localparam int PSD_B_CTRL_SEL = 8;
  // Crossover status bits
  localparam int PSD_X_AUTO = 0;
  localparam int PSD_X_CROSSED = 1;
  localparam logic PSD_RST_AUTO_XOVER = 1'b1;
  localparam logic PSD_RST_MANUAL_XOVER = 1'b0;
  localparam logic PSD_RST_AUTONEG = 1'b1;
  localparam logic PSD_RST_SPEED = 1'b1;
  localparam logic PSD_RST_DUPLEX = 1'b1;
  localparam logic [2:0] PSD_MODE_10HD = 3'h0;
  localparam logic [2:0] PSD_MODE_10FD = 3'h1;
  localparam logic [2:0] PSD_MODE_100HD = 3'h2;
  localparam logic [2:0] PSD_MODE_100FD = 3'h3;
  localparam logic [2:0] PSD_MODE_AN = 3'h7;
  typedef enum logic {PSD_ST_RESET, PSD_ST_RUN} psd_state_e;
endpackage
`default_nettype wire

/* rtl/psd_strap_map.sv */
`default_nettype none
module psd_strap_map
  import psd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic fibre_a,
  input wire logic fibre_b,
  input wire logic energy_saving_strap_pin,
  input wire logic auto_crossover_strap,
  input wire logic manual_crossover_strap,
  input wire logic autoneg_strap,
  input wire logic speed_strap,
  input wire logic duplex_strap,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic [2:0] phya_cfg,
  output logic [8:0] phyb_cfg,
  output logic auto_crossover_strap_state,
  output logic crossover_active,
  output logic crossover_crossed
);
  psd_state_e state;
  psd_state_e next_state;
  logic [5:0] straps;
  logic [5:0] next_straps;
  logic straps_loaded;
  logic next_straps_loaded;
  logic [2:0] next_phya_cfg;
  logic [8:0] next_phyb_cfg;
  logic next_auto_crossover_strap_state;
  logic [15:0] next_rdata;
  logic auto_x;
  logic manual_x;
  psd_if bmap ();
  assign bmap.fibre = fibre_b;
  assign bmap.autoneg = straps[3];
  assign bmap.speed = straps[4];
  assign bmap.duplex = straps[5];
  psd_phyb_map u_map (.m(bmap));
  // Crossover decision: software select bit chooses straps, else auto
  always_comb
  begin
    auto_x = fibre_b ? 1'b0 : straps[1];
    manual_x = fibre_b ? 1'b0 : straps[2];
    if (phyb_cfg[PSD_B_CTRL_SEL])
    begin
      crossover_active = auto_x;
      crossover_crossed = auto_x ? 1'b0 : manual_x;
    end
    else
    begin
      crossover_active = ~fibre_b;
      crossover_crossed = 1'b0;
    end
  end
  always_comb
  begin
    next_state = state;
    next_straps = straps;
    next_straps_loaded = straps_loaded;
    next_phya_cfg = phya_cfg;
    next_phyb_cfg = phyb_cfg;
    next_auto_crossover_strap_state = auto_crossover_strap_state;
    next_rdata = '0;
    case (state)
      PSD_ST_RESET:
      begin
        // Straps are caught on the first edge after release, never under async reset
        next_straps = {duplex_strap, speed_strap, autoneg_strap, manual_crossover_strap,
          auto_crossover_strap, energy_saving_strap_pin};
        next_state = PSD_ST_RUN;
      end
      PSD_ST_RUN:
      begin
        next_straps_loaded = 1'b1;
        if (!straps_loaded)
        begin
          // The load edge wins over a write so the defaults always land once per reset
          next_phya_cfg = {3{straps[0] & ~fibre_a}};
          next_phyb_cfg = {phyb_cfg[PSD_B_CTRL_SEL], bmap.value[7:0]};
          next_auto_crossover_strap_state = straps[1];
        end
        else if (wr)
        begin
          case (addr)
            PSD_ADDR_PHYA: next_phya_cfg = wdata[2:0];
            PSD_ADDR_PHYB: next_phyb_cfg = wdata[8:0];
            PSD_ADDR_HWCFG: next_auto_crossover_strap_state = wdata[0];
            default: ;
          endcase
        end
      end
      default:
      begin
        next_state = PSD_ST_RESET;
      end
    endcase
    if (rd)
    begin
      case (addr)
        PSD_ADDR_PHYA: next_rdata = {13'h0, phya_cfg};
        PSD_ADDR_PHYB: next_rdata = {7'h0, phyb_cfg};
        PSD_ADDR_HWCFG: next_rdata = {15'h0, auto_crossover_strap_state};
        PSD_ADDR_XOVER: next_rdata = {14'h0, crossover_crossed, crossover_active};
        PSD_ADDR_STRAPS: next_rdata = {8'h0, fibre_b, fibre_a, straps};
        default: next_rdata = '0;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= PSD_ST_RESET;
      straps <= {PSD_RST_DUPLEX, PSD_RST_SPEED, PSD_RST_AUTONEG, PSD_RST_MANUAL_XOVER,
        PSD_RST_AUTO_XOVER, 1'b0};
      straps_loaded <= 1'b0;
      phya_cfg <= '0;
      phyb_cfg <= '0;
      auto_crossover_strap_state <= PSD_RST_AUTO_XOVER;
      rdata <= '0;
    end
    else
    begin
      state <= next_state;
      straps <= next_straps;
      straps_loaded <= next_straps_loaded;
      phya_cfg <= next_phya_cfg;
      phyb_cfg <= next_phyb_cfg;
      auto_crossover_strap_state <= next_auto_crossover_strap_state;
      rdata <= next_rdata;
    end
  end
  // Checks
  property p_eee_load;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded) |=> (phya_cfg == {3{$past(straps[0]) & ~$past(fibre_a)}});
  endproperty
  a_eee_load: assert property (p_eee_load) else $error("energy defaults wrong");
  property p_fibre_an;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && fibre_b) |=> !phyb_cfg[PSD_B_AN_EN];
  endproperty
  a_fibre_an: assert property (p_fibre_an) else $error("fibre autoneg set");
  property p_amdix;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded) |=> auto_crossover_strap_state == $past(straps[1]);
  endproperty
  a_amdix: assert property (p_amdix) else $error("strap state wrong");
  property p_xsel;
    @(posedge mclk) disable iff (rst)
    (phyb_cfg[PSD_B_CTRL_SEL] && !fibre_b) |-> crossover_active == straps[1];
  endproperty
  a_xsel: assert property (p_xsel) else $error("crossover select wrong");
  property p_manual;
    @(posedge mclk) disable iff (rst)
    (phyb_cfg[PSD_B_CTRL_SEL] && !fibre_b && !straps[1]) |-> crossover_crossed == straps[2];
  endproperty
  a_manual: assert property (p_manual) else $error("manual crossover wrong");
  property p_an;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && !fibre_b) |=> phyb_cfg[PSD_B_AN_EN] == $past(straps[3]);
  endproperty
  a_an: assert property (p_an) else $error("autoneg default wrong");
  property p_an_mode;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && !fibre_b && straps[3])
      |=> phyb_cfg[PSD_B_MODE_LO +: 3] == PSD_MODE_AN;
  endproperty
  a_an_mode: assert property (p_an_mode) else $error("mode not autoneg");
  property p_speed;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && !fibre_b && !straps[3])
      |=> phyb_cfg[PSD_B_SPEED_LSB] == $past(straps[4]) && phyb_cfg[PSD_B_ADV_10HD] == !$past(straps[4]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed default wrong");
  property p_duplex;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && !fibre_b && !straps[3])
      |=> phyb_cfg[PSD_B_DUPLEX] == $past(straps[5]);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex default wrong");
  property p_hold;
    @(posedge mclk) disable iff (rst)
    (straps_loaded && !wr) |=> $stable(phya_cfg) && $stable(phyb_cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("defaults moved");
  property p_eee_fibre;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && fibre_a) |=> phya_cfg == 3'h0;
  endproperty
  a_eee_fibre: assert property (p_eee_fibre) else $error("fibre energy bits set");
  property p_fibre_b;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && fibre_b)
      |=> phyb_cfg[PSD_B_SPEED_LSB] && phyb_cfg[PSD_B_DUPLEX] == $past(straps[5]);
  endproperty
  a_fibre_b: assert property (p_fibre_b) else $error("fibre speed or duplex wrong");
  property p_an_force;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && !fibre_b && straps[3])
      |=> phyb_cfg[PSD_B_SPEED_LSB] && phyb_cfg[PSD_B_DUPLEX] && phyb_cfg[PSD_B_ADV_10HD];
  endproperty
  a_an_force: assert property (p_an_force) else $error("autoneg side bits wrong");
  property p_adv_fd;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && !fibre_b && !straps[3])
      |=> phyb_cfg[PSD_B_ADV_10FD] == (!$past(straps[4]) && $past(straps[5]));
  endproperty
  a_adv_fd: assert property (p_adv_fd) else $error("full duplex advert wrong");
  property p_mode_fixed;
    @(posedge mclk) disable iff (rst)
    (state == PSD_ST_RUN && !straps_loaded && !fibre_b && !straps[3])
      |=> phyb_cfg[PSD_B_MODE_LO +: 3] == {1'b0, $past(straps[4]), $past(straps[5])};
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("fixed mode wrong");
  property p_auto_sel;
    @(posedge mclk) disable iff (rst)
    !phyb_cfg[PSD_B_CTRL_SEL] |-> crossover_active == !fibre_b && !crossover_crossed;
  endproperty
  a_auto_sel: assert property (p_auto_sel) else $error("auto crossover wrong");
  property p_xfibre;
    @(posedge mclk) disable iff (rst)
    fibre_b |-> !crossover_active && !crossover_crossed;
  endproperty
  a_xfibre: assert property (p_xfibre) else $error("fibre crossover active");
  property p_straps_once;
    @(posedge mclk) disable iff (rst)
    straps_loaded |=> $stable(straps);
  endproperty
  a_straps_once: assert property (p_straps_once) else $error("straps recaptured");
  property p_wr_land;
    @(posedge mclk) disable iff (rst)
    (straps_loaded && wr && addr == PSD_ADDR_PHYB) |=> phyb_cfg == $past(wdata[8:0]);
  endproperty
  a_wr_land: assert property (p_wr_land) else $error("software write lost");
  c_load: cover property (@(posedge mclk) disable iff (rst) state == PSD_ST_RUN && !straps_loaded);
  c_fibre: cover property (@(posedge mclk) disable iff (rst) straps_loaded && fibre_b);
  c_crossed: cover property (@(posedge mclk) disable iff (rst) crossover_crossed);
  c_select: cover property (@(posedge mclk) disable iff (rst) phyb_cfg[PSD_B_CTRL_SEL] && crossover_active);
  c_fixed: cover property (@(posedge mclk) disable iff (rst) state == PSD_ST_RUN && !straps_loaded && !straps[3]);
endmodule
`default_nettype wire

/* sim/psd_strap_map_tb.sv */
`default_nettype none
module psd_strap_map_tb
  import psd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ovr = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] pat = 8'h00;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [2:0] phya_cfg;
  logic [8:0] phyb_cfg;
  logic fa, fb, ee, au, ma, an, sp, dx, st, xa, xc;
  int mismatches = 0;
  int checked = 0;
  always #2.5 mclk = ~mclk;
  psd_strap_src src_u (.ovr(ovr), .pat(pat), .fibre_a(fa), .fibre_b(fb), .energy(ee), .auto_x(au),
    .manual_x(ma), .autoneg(an), .speed(sp), .duplex(dx));
  psd_strap_map dut_u (.mclk(mclk), .rst(rst), .fibre_a(fa), .fibre_b(fb), .energy_saving_strap_pin(ee),
    .auto_crossover_strap(au), .manual_crossover_strap(ma), .autoneg_strap(an), .speed_strap(sp),
    .duplex_strap(dx), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phya_cfg(phya_cfg),
    .phyb_cfg(phyb_cfg), .auto_crossover_strap_state(st), .crossover_active(xa), .crossover_crossed(xc));
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bit 8 is masked from the default and hold checks; with fibre only bits 2:0 are compared, and the adverts and mode the map still drives are masked off
  function automatic logic [8:0] exp_b(input logic [7:0] p);
    if (p[6])
      return {6'h00, p[0], 2'b10};
    if (p[2])
      return {1'b0, 3'h7, 1'b1, p[0], 3'b111};
    return {1'b0, 1'b0, p[1], p[0], ~p[1], ~p[1] & p[0], p[0], p[1], 1'b0};
  endfunction
  task automatic run_case(input logic [7:0] p, input logic o);
    logic [8:0] m;
    logic [8:0] e;
    logic [15:0] got;
    m = p[6] ? 9'h007 : 9'h0ff;
    e = exp_b(p);
    @(posedge mclk);
    ovr <= o;
    pat <= p;
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("cfg_b_in_reset", 16'(phyb_cfg), 16'h0000);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("cfg_a", 16'(phya_cfg), p[7] ? 16'h0000 : {13'h0000, {3{p[5]}}});
    chk("cfg_b", 16'(phyb_cfg & m), 16'(e & m));
    if (!p[6])
      chk("strap_state", 16'(st), 16'(p[4]));
    rd_reg(PSD_ADDR_PHYB, got);
    chk("rd_b", got & 16'(m), 16'(e & m));
    rd_reg(PSD_ADDR_PHYA, got);
    chk("rd_a", got, p[7] ? 16'h0000 : {13'h0000, {3{p[5]}}});
    @(posedge mclk);
    ovr <= 1'b1;
    pat <= p ^ 8'h3f;
    repeat (4) @(posedge mclk);
    #1 chk("hold_b", 16'(phyb_cfg & m), 16'(e & m));
    chk("x_auto_active", 16'(xa), {15'h0000, ~p[6]});
    chk("x_auto_crossed", 16'(xc), 16'h0000);
    ovr <= o;
    pat <= p;
    got = {7'h00, 1'b1, phyb_cfg[7:0]};
    wr_reg(PSD_ADDR_PHYB, got);
    chk("wr_b", 16'(phyb_cfg), got);
    chk("x_active", 16'(xa), {15'h0000, ~p[6] & p[4]});
    chk("x_crossed", 16'(xc), {15'h0000, ~p[6] & ~p[4] & p[3]});
    rd_reg(PSD_ADDR_XOVER, got);
    chk("rd_x", got, {14'h0000, ~p[6] & ~p[4] & p[3], ~p[6] & p[4]});
    got = {15'h0000, ~st};
    wr_reg(PSD_ADDR_HWCFG, got);
    chk("wr_hw", 16'(st), got);
    rd_reg(4'h9, got);
    chk("rd_unmapped", got, 16'h0000);
    $display("case %h done", p);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    run_case(8'h37, 1'b0);
    run_case(8'h08, 1'b1);
    run_case(8'h22, 1'b1);
    run_case(8'h19, 1'b1);
    run_case(8'hff, 1'b1);
    run_case(8'h7a, 1'b1);
    summarize();
  end
  // Guards against a hang anywhere in the sequence
  initial
  begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire

/* sim/psd_strap_src.sv */
`default_nettype none
module psd_strap_src
  import psd_pkg::*;
#(
  // Straps unmodified: fibre off, energy on, auto 1, manual 0, autoneg 1, speed 1, duplex 1
  parameter logic [7:0] DEF = 8'h37
)
(
  input wire logic ovr,
  input wire logic [7:0] pat,
  output logic fibre_a,
  output logic fibre_b,
  output logic energy,
  output logic auto_x,
  output logic manual_x,
  output logic autoneg,
  output logic speed,
  output logic duplex
);
  timeunit 1ns;
  timeprecision 1ps;
  // Resistor-set levels never float, so they simply hold
  assign {fibre_a, fibre_b, energy, auto_x, manual_x, autoneg, speed, duplex} = ovr ? pat : DEF;
endmodule
`default_nettype wire
